// file: hw/mmr_window.sv
// Peripheral register window decoder with serial and transfer subbanks
`timescale 1ns/1ps
`include "mmr_window_defs.svh"

// Contract
// - Each serial port has a subbank pointer
// - Window reads/writes the register the pointer selects
// - Port 0 pointer at 38h, window 39h
// - Port 1 pointer at 48h, window 49h
// - Port 2 pointer at 34h, window 35h
// - Indices 00h-0Eh select the basic control set
// - Indices 10h-1Bh select extra channel enables
// - Host control at 2Ch only when mux select zero
// - Wait config 28h, bank switch 29h, wait control 2Bh
// - Port 2 data words at 30h-33h
// - Port 1 data words at 40h-43h
// - Pin direction 3Ch, pin status 3Dh, ID 3Eh
// - Transfer priority 54h, pointer 55h, windows 56h/57h
// - Clock mode register at 58h
// - Access through 56h advances transfer pointer
// - Port 0 data words at 20h-23h
module mmr_window
  import mmr_window_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a00 // Arbitrary identity value
)(
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  input  wire logic                                  clk_en,
  input  wire logic [15:0]                           mem_addr,
  input  wire logic                                  mem_rd,
  input  wire logic                                  mem_wr,
  input  wire logic [15:0]                           mem_wdata,
  output logic      [15:0]                           mem_rdata,
  output logic                                       mem_rvalid,
  input  wire logic                                  host_port_mux_select,
  input  wire logic [2:0][1:0][15:0]                 rx_word,
  output logic      [2:0]                            rx_taken,
  output logic      [2:0][1:0][15:0]                 tx_word,
  output logic      [2:0][1:0]                       tx_loaded,
  output logic      [2:0][`SER_BANK_DEPTH-1:0][15:0] ser_ctl,
  output logic      [15:0]                           wait_state_config,
  output logic      [15:0]                           bank_switch_control,
  output logic      [15:0]                           wait_state_control,
  output logic      [15:0]                           host_port_control,
  output logic      [15:0]                           clock_mode_control,
  output logic      [15:0]                           transfer_priority_enable,
  output logic      [7:0]                            pin_direction_control,
  output logic      [7:0]                            pin_level_out,
  input  wire logic [7:0]                            pin_level_in,
  output logic      [15:0]                           transfer_bank_pointer,
  input  wire logic [15:0]                           transfer_rdata,
  output logic                                       transfer_rd,
  output logic                                       transfer_wr,
  output logic      [15:0]                           transfer_addr,
  output logic      [15:0]                           transfer_wdata
);

  mmr_state_t  state_ff;
  mmr_state_t  nxt_state;
  sel_t        sel;
  logic [1:0]  prt;
  logic [2:0]  ptr_wr;
  logic [2:0]  win_wr;
  logic [2:0][15:0] ser_ptr;
  logic [2:0][15:0] win_rdata;
  logic [15:0] pin_read;

  // Word address to register kind; the serial port comes from port_of
  function automatic sel_t reg_sel(input logic [15:0] a);
    case (a)
      `WAIT_CFG_ADDR:     reg_sel = SEL_WAIT_CFG;
      `BANK_SW_ADDR:      reg_sel = SEL_BANK_SW;
      `WAIT_CTL_ADDR:     reg_sel = SEL_WAIT_CTL;
      `HOST_CTL_ADDR:     reg_sel = SEL_HOST;
      `P0_RX_HI_ADDR, `P1_RX_HI_ADDR, `P2_RX_HI_ADDR:
        reg_sel = SEL_RX_HI;
      `P0_RX_LO_ADDR, `P1_RX_LO_ADDR, `P2_RX_LO_ADDR:
        reg_sel = SEL_RX_LO;
      `P0_TX_HI_ADDR, `P1_TX_HI_ADDR, `P2_TX_HI_ADDR:
        reg_sel = SEL_TX_HI;
      `P0_TX_LO_ADDR, `P1_TX_LO_ADDR, `P2_TX_LO_ADDR:
        reg_sel = SEL_TX_LO;
      `P0_PTR_ADDR, `P1_PTR_ADDR, `P2_PTR_ADDR:
        reg_sel = SEL_SER_PTR;
      `P0_WIN_ADDR, `P1_WIN_ADDR, `P2_WIN_ADDR:
        reg_sel = SEL_SER_WIN;
      `PIN_DIR_ADDR:      reg_sel = SEL_PIN_DIR;
      `PIN_LVL_ADDR:      reg_sel = SEL_PIN_LVL;
      `PART_ID_ADDR:      reg_sel = SEL_PART_ID;
      `XFER_PRIO_ADDR:    reg_sel = SEL_XFER_PRIO;
      `XFER_PTR_ADDR:     reg_sel = SEL_XFER_PTR;
      `XFER_WIN_INC_ADDR: reg_sel = SEL_XFER_WIN_INC;
      `XFER_WIN_ADDR:     reg_sel = SEL_XFER_WIN;
      `CLK_MODE_ADDR:     reg_sel = SEL_CLK_MODE;
      default:            reg_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic [1:0] port_of(input logic [15:0] a);
    case (a[7:4])
      4'h2:    port_of = 2'd0;
      4'h3:    port_of = (a[3:0] >= 4'h8) ? 2'd0 : 2'd2;
      default: port_of = 2'd1;
    endcase
  endfunction

  assign sel = reg_sel(mem_addr);
  assign prt = port_of(mem_addr);

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      assign ptr_wr[p] = mem_wr && (sel == SEL_SER_PTR) && (prt == 2'(p));
      assign win_wr[p] = mem_wr && (sel == SEL_SER_WIN) && (prt == 2'(p));
      serial_bank u_bank (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .ptr_wr    (ptr_wr[p]),
        .win_wr    (win_wr[p]),
        .wr_data   (mem_wdata),
        .ptr_q     (ser_ptr[p]),
        .ctl_q     (ser_ctl[p]),
        .win_rdata (win_rdata[p])
      );
    end
  endgenerate

  // Input pins show the live level, output pins the driven value
  assign pin_read = ((state_ff.pin_dir & state_ff.pin_lvl) |
                     (~state_ff.pin_dir & {8'h00, pin_level_in})) &
                    `PIN_FIELD_MASK;

  always_comb begin
    nxt_state          = state_ff;
    nxt_state.tx_wr    = '0;
    nxt_state.rx_rd    = '0;
    nxt_state.xfer_wr  = 1'b0;
    nxt_state.xfer_rd  = 1'b0;
    nxt_state.rd_valid = mem_rd;
    if (mem_rd) begin
      case (sel)
        SEL_WAIT_CFG: nxt_state.rd_data = state_ff.wait_cfg;
        SEL_BANK_SW:  nxt_state.rd_data = state_ff.bank_sw;
        SEL_WAIT_CTL: nxt_state.rd_data = state_ff.wait_ctl;
        SEL_HOST: begin
          // Absent while the host pins are muxed to the other mode
          nxt_state.rd_data = host_port_mux_select ? 16'h0000
                                                   : state_ff.host_ctl;
        end
        SEL_RX_HI: begin
          nxt_state.rd_data   = rx_word[prt][1];
          nxt_state.rx_rd[prt] = 1'b1;
        end
        SEL_RX_LO: begin
          nxt_state.rd_data   = rx_word[prt][0];
          nxt_state.rx_rd[prt] = 1'b1;
        end
        SEL_TX_HI:    nxt_state.rd_data = state_ff.tx[prt][1];
        SEL_TX_LO:    nxt_state.rd_data = state_ff.tx[prt][0];
        SEL_SER_PTR:  nxt_state.rd_data = ser_ptr[prt];
        SEL_SER_WIN:  nxt_state.rd_data = win_rdata[prt];
        SEL_PIN_DIR:  nxt_state.rd_data = state_ff.pin_dir;
        SEL_PIN_LVL:  nxt_state.rd_data = pin_read;
        SEL_PART_ID:  nxt_state.rd_data = PART_ID;
        SEL_XFER_PRIO: nxt_state.rd_data = state_ff.xfer_prio;
        SEL_XFER_PTR: nxt_state.rd_data = state_ff.xfer_ptr;
        SEL_XFER_WIN_INC, SEL_XFER_WIN: begin
          nxt_state.rd_data   = transfer_rdata;
          nxt_state.xfer_rd   = 1'b1;
          nxt_state.xfer_addr = state_ff.xfer_ptr;
        end
        SEL_CLK_MODE: nxt_state.rd_data = state_ff.clk_mode;
        default:      nxt_state.rd_data = 16'h0000;
      endcase
    end
    if (mem_wr) begin
      case (sel)
        SEL_WAIT_CFG: nxt_state.wait_cfg = mem_wdata;
        SEL_BANK_SW:  nxt_state.bank_sw  = mem_wdata;
        SEL_WAIT_CTL: nxt_state.wait_ctl = mem_wdata;
        SEL_HOST: begin
          if (!host_port_mux_select) begin
            nxt_state.host_ctl = mem_wdata;
          end
        end
        SEL_TX_HI: begin
          nxt_state.tx[prt][1]    = mem_wdata;
          nxt_state.tx_wr[prt][1] = 1'b1;
        end
        SEL_TX_LO: begin
          nxt_state.tx[prt][0]    = mem_wdata;
          nxt_state.tx_wr[prt][0] = 1'b1;
        end
        SEL_PIN_DIR:  nxt_state.pin_dir = mem_wdata & `PIN_FIELD_MASK;
        SEL_PIN_LVL:  nxt_state.pin_lvl = mem_wdata & `PIN_FIELD_MASK;
        SEL_XFER_PRIO: nxt_state.xfer_prio = mem_wdata;
        SEL_XFER_PTR: nxt_state.xfer_ptr  = mem_wdata;
        SEL_XFER_WIN_INC, SEL_XFER_WIN: begin
          nxt_state.xfer_wr   = 1'b1;
          nxt_state.xfer_addr = state_ff.xfer_ptr;
          nxt_state.xfer_data = mem_wdata;
        end
        SEL_CLK_MODE: nxt_state.clk_mode = mem_wdata;
        default: begin
          // Serial subbank writes land in the bank instances
        end
      endcase
    end
    // One step per access even when a read and write coincide
    if ((mem_rd || mem_wr) && (sel == SEL_XFER_WIN_INC)) begin
      nxt_state.xfer_ptr = state_ff.xfer_ptr + 16'h0001;
    end
  end

  // Low clk_en holds every register, strobes included
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff           <= '0;
      state_ff.wait_cfg  <= `REG_RESET_VALUE;
      state_ff.bank_sw   <= `REG_RESET_VALUE;
      state_ff.wait_ctl  <= `REG_RESET_VALUE;
      state_ff.host_ctl  <= `REG_RESET_VALUE;
      state_ff.clk_mode  <= `REG_RESET_VALUE;
      state_ff.xfer_prio <= `REG_RESET_VALUE;
      state_ff.xfer_ptr  <= `REG_RESET_VALUE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign mem_rdata                = state_ff.rd_data;
  assign mem_rvalid               = state_ff.rd_valid;
  assign rx_taken                 = state_ff.rx_rd;
  assign tx_word                  = state_ff.tx;
  assign tx_loaded                = state_ff.tx_wr;
  assign wait_state_config        = state_ff.wait_cfg;
  assign bank_switch_control      = state_ff.bank_sw;
  assign wait_state_control       = state_ff.wait_ctl;
  assign host_port_control        = state_ff.host_ctl;
  assign clock_mode_control       = state_ff.clk_mode;
  assign transfer_priority_enable = state_ff.xfer_prio;
  assign pin_direction_control    = state_ff.pin_dir[7:0];
  assign pin_level_out            = state_ff.pin_lvl[7:0];
  assign transfer_bank_pointer    = state_ff.xfer_ptr;
  assign transfer_rd              = state_ff.xfer_rd;
  assign transfer_wr              = state_ff.xfer_wr;
  assign transfer_addr            = state_ff.xfer_addr;
  assign transfer_wdata           = state_ff.xfer_data;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wr(logic [15:0] a);
    clk_en && mem_wr && (mem_addr == a);
  endsequence

  sequence s_rd(logic [15:0] a);
    clk_en && mem_rd && (mem_addr == a);
  endsequence

  sequence s_xfer_acc(logic [15:0] a);
    clk_en && (mem_rd || mem_wr) && (mem_addr == a);
  endsequence

  chk_port0_ptr_load: assert property (
    s_wr(`P0_PTR_ADDR) |=> ser_ptr[0] == $past(mem_wdata))
    else $error("port 0 pointer not loaded at 38h");

  chk_port1_ptr_load: assert property (
    s_wr(`P1_PTR_ADDR) |=> ser_ptr[1] == $past(mem_wdata))
    else $error("port 1 pointer not loaded at 48h");

  chk_port2_ptr_load: assert property (
    s_wr(`P2_PTR_ADDR) |=> ser_ptr[2] == $past(mem_wdata))
    else $error("port 2 pointer not loaded at 34h");

  chk_window_read_sel: assert property (
    s_rd(`P0_WIN_ADDR) |=> mem_rdata == $past(win_rdata[0]))
    else $error("port 0 window read wrong register");

  chk_pin_ctl_slot: assert property (
    s_wr(`P2_WIN_ADDR) and (ser_ptr[2] == 16'h000e)
    |=> ser_ctl[2][`IDX_PIN_CTL] == $past(mem_wdata))
    else $error("pin control slot not written via window");

  chk_ext_slot_read: assert property (
    s_rd(`P1_WIN_ADDR) and (ser_ptr[1] == 16'h001b)
    |=> mem_rdata == $past(ser_ctl[1][`IDX_EXT_LAST]))
    else $error("last extended slot read wrong");

  chk_host_gated: assert property (
    s_rd(`HOST_CTL_ADDR) and host_port_mux_select |=> mem_rdata == 16'h0000)
    else $error("host control visible in other mux mode");

  chk_host_hold: assert property (
    s_wr(`HOST_CTL_ADDR) and host_port_mux_select
    |=> $stable(host_port_control))
    else $error("host control written in other mux mode");

  chk_wait_cfg_back: assert property (
    s_wr(`WAIT_CFG_ADDR) ##1 !(clk_en && mem_wr) ##1 s_rd(`WAIT_CFG_ADDR)
    |=> mem_rdata == $past(mem_wdata, 3))
    else $error("wait config did not read back");

  chk_port2_rx_read: assert property (
    s_rd(`P2_RX_HI_ADDR)
    |=> (mem_rdata == $past(rx_word[2][1])) && rx_taken[2])
    else $error("port 2 high receive word wrong");

  chk_port1_rx_read: assert property (
    s_rd(`P1_RX_LO_ADDR)
    |=> (mem_rdata == $past(rx_word[1][0])) && rx_taken[1])
    else $error("port 1 low receive word wrong");

  chk_part_id_read: assert property (
    s_rd(`PART_ID_ADDR) |=> mem_rdata == PART_ID)
    else $error("identification read wrong");

  chk_plain_window: assert property (
    s_xfer_acc(`XFER_WIN_ADDR) |=> $stable(transfer_bank_pointer))
    else $error("plain transfer window moved pointer");

  chk_xfer_write_out: assert property (
    s_wr(`XFER_WIN_ADDR) |=> transfer_wr &&
    (transfer_addr == $past(transfer_bank_pointer)) &&
    (transfer_wdata == $past(mem_wdata)))
    else $error("transfer window write not forwarded");

  chk_clk_mode_load: assert property (
    s_wr(`CLK_MODE_ADDR) |=> clock_mode_control == $past(mem_wdata))
    else $error("clock mode not loaded at 58h");

  chk_autoinc_step: assert property (
    s_xfer_acc(`XFER_WIN_INC_ADDR)
    |=> transfer_bank_pointer == $past(transfer_bank_pointer) + 16'h0001)
    else $error("transfer pointer did not advance");

  chk_port0_tx_load: assert property (
    s_wr(`P0_TX_LO_ADDR)
    |=> (tx_word[0][0] == $past(mem_wdata)) && tx_loaded[0][0])
    else $error("port 0 low transmit word not loaded");

  chk_reserved_zero: assert property (
    s_rd(`RESERVED_PROBE) |=> mem_rdata == 16'h0000)
    else $error("reserved address read nonzero");

  chk_read_latency: assert property (
    clk_en && mem_rd |=> mem_rvalid)
    else $error("read answer not one cycle later");

endmodule

// file: hw/mmr_window_defs.svh
// Word addresses, subbank indices and reset values of the register window
`ifndef MMR_WINDOW_DEFS_SVH
`define MMR_WINDOW_DEFS_SVH

`define P0_RX_HI_ADDR      16'h0020
`define P0_RX_LO_ADDR      16'h0021
`define P0_TX_HI_ADDR      16'h0022
`define P0_TX_LO_ADDR      16'h0023
`define WAIT_CFG_ADDR      16'h0028
`define BANK_SW_ADDR       16'h0029
`define WAIT_CTL_ADDR      16'h002b
`define HOST_CTL_ADDR      16'h002c
`define P2_RX_HI_ADDR      16'h0030
`define P2_RX_LO_ADDR      16'h0031
`define P2_TX_HI_ADDR      16'h0032
`define P2_TX_LO_ADDR      16'h0033
`define P2_PTR_ADDR        16'h0034
`define P2_WIN_ADDR        16'h0035
`define P0_PTR_ADDR        16'h0038
`define P0_WIN_ADDR        16'h0039
`define PIN_DIR_ADDR       16'h003c
`define PIN_LVL_ADDR       16'h003d
`define PART_ID_ADDR       16'h003e
`define P1_RX_HI_ADDR      16'h0040
`define P1_RX_LO_ADDR      16'h0041
`define P1_TX_HI_ADDR      16'h0042
`define P1_TX_LO_ADDR      16'h0043
`define P1_PTR_ADDR        16'h0048
`define P1_WIN_ADDR        16'h0049
`define XFER_PRIO_ADDR     16'h0054
`define XFER_PTR_ADDR      16'h0055
`define XFER_WIN_INC_ADDR  16'h0056
`define XFER_WIN_ADDR      16'h0057
`define CLK_MODE_ADDR      16'h0058
`define RESERVED_PROBE     16'h002a

// Subbank order: control 1/2, rx 1/2, tx 1/2, rate 1/2, multichannel 1/2,
// rx enable A/B, tx enable A/B, pin control; then rx C,D tx C,D ... tx G,H
`define IDX_PORT_CTL_ONE   5'h00
`define IDX_PIN_CTL        5'h0e
`define IDX_EXT_FIRST      5'h10
`define IDX_EXT_LAST       5'h1b
`define SER_BANK_DEPTH     28

`define REG_RESET_VALUE    16'h0000
`define PIN_FIELD_MASK     16'h00ff

`endif

// file: hw/mmr_window_pkg.sv
// Types shared by the register window and the serial subbank
package mmr_window_pkg;
`include "mmr_window_defs.svh"

  typedef enum logic [4:0] {
    SEL_NONE, SEL_WAIT_CFG, SEL_BANK_SW, SEL_WAIT_CTL, SEL_HOST,
    SEL_RX_HI, SEL_RX_LO, SEL_TX_HI, SEL_TX_LO, SEL_SER_PTR,
    SEL_SER_WIN, SEL_PIN_DIR, SEL_PIN_LVL, SEL_PART_ID,
    SEL_XFER_PRIO, SEL_XFER_PTR, SEL_XFER_WIN_INC, SEL_XFER_WIN,
    SEL_CLK_MODE
  } sel_t;

  typedef struct packed {
    logic [15:0]                      ptr;
    logic [`SER_BANK_DEPTH-1:0][15:0] ctl;
  } ser_bank_state_t;

  typedef struct packed {
    logic [15:0]           wait_cfg;
    logic [15:0]           bank_sw;
    logic [15:0]           wait_ctl;
    logic [15:0]           host_ctl;
    logic [15:0]           pin_dir;
    logic [15:0]           pin_lvl;
    logic [15:0]           xfer_prio;
    logic [15:0]           xfer_ptr;
    logic [15:0]           clk_mode;
    logic [2:0][1:0][15:0] tx;
    logic [2:0][1:0]       tx_wr;
    logic [2:0]            rx_rd;
    logic                  xfer_wr;
    logic                  xfer_rd;
    logic [15:0]           xfer_addr;
    logic [15:0]           xfer_data;
    logic [15:0]           rd_data;
    logic                  rd_valid;
  } mmr_state_t;
endpackage

// file: hw/serial_bank.sv
// Pointer and indirect control-register bank of one serial port
`timescale 1ns/1ps
`include "mmr_window_defs.svh"
module serial_bank
  import mmr_window_pkg::*;
(
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clk_en,
  input  wire logic                             ptr_wr,
  input  wire logic                             win_wr,
  input  wire logic [15:0]                      wr_data,
  output logic      [15:0]                      ptr_q,
  output logic      [`SER_BANK_DEPTH-1:0][15:0] ctl_q,
  output logic      [15:0]                      win_rdata
);

  ser_bank_state_t state_ff;
  ser_bank_state_t nxt_state;
  logic            idx_ok;
  logic [4:0]      idx;

  // Slot 0Fh and anything past 1Bh reach nothing
  assign idx    = state_ff.ptr[4:0];
  assign idx_ok = (state_ff.ptr[15:5] == 11'h000) &&
                  ((idx <= `IDX_PIN_CTL) ||
                   ((idx >= `IDX_EXT_FIRST) && (idx <= `IDX_EXT_LAST)));

  always_comb begin
    nxt_state = state_ff;
    if (ptr_wr) begin
      nxt_state.ptr = wr_data;
    end
    if (win_wr && idx_ok) begin
      nxt_state.ctl[idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign ptr_q     = state_ff.ptr;
  assign ctl_q     = state_ff.ctl;
  assign win_rdata = idx_ok ? state_ff.ctl[idx] : 16'h0000;

endmodule

// file: tb/peripheral_mmr_decoder_subbank_tb.sv
// Self-checking bench for the peripheral register window decoder
`timescale 1ns/1ps
module peripheral_mmr_decoder_subbank_tb;
  import mmr_window_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   clk_en = 1'b1;
  logic                   mem_rd = 1'b0;
  logic                   mem_wr = 1'b0;
  logic                   mux_sel = 1'b0;
  logic [15:0]            mem_addr = 16'h0000;
  logic [15:0]            mem_wdata = 16'h0000;
  logic [7:0]             pin_in = 8'h00;
  logic [2:0][1:0][15:0]  rx_word = '0;
  logic [2:0][1:0][15:0]  tx_word;
  logic [2:0][27:0][15:0] ser_ctl;
  logic [2:0]             rx_taken, rx_seen;
  logic [2:0][1:0]        tx_loaded;
  logic [5:0]             tx_seen;
  logic [15:0]            mem_rdata, wcfg, bsw, wctl, hctl, clkm, prio;
  logic [15:0]            xptr, xrdata, xaddr, xwdata, d, e, a;
  logic [7:0]             pdir, plvl;
  logic                   mem_rvalid, xrd, xwr, xw_seen, xr_seen;
  int                     n_fail = 0;
  int                     tests_run = 0;
  int                     cycles = 0;
  logic [7:0] dir_a [6] = '{8'h28, 8'h29, 8'h2b, 8'h2c, 8'h54, 8'h58};
  logic [7:0] rsv_a [9] = '{8'h27, 8'h2a, 8'h2d, 8'h36, 8'h3a, 8'h3f,
                            8'h44, 8'h53, 8'h5f};
  logic [7:0] ptr_a [3] = '{8'h38, 8'h48, 8'h34};
  logic [7:0] dat_a [3] = '{8'h20, 8'h40, 8'h30};

  mmr_window #(.PART_ID(16'h1e07)) dut ( // Identity value is arbitrary
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .host_port_mux_select(mux_sel), .rx_word(rx_word),
    .rx_taken(rx_taken), .tx_word(tx_word), .tx_loaded(tx_loaded),
    .ser_ctl(ser_ctl), .wait_state_config(wcfg),
    .bank_switch_control(bsw), .wait_state_control(wctl),
    .host_port_control(hctl), .clock_mode_control(clkm),
    .transfer_priority_enable(prio), .pin_direction_control(pdir),
    .pin_level_out(plvl), .pin_level_in(pin_in),
    .transfer_bank_pointer(xptr), .transfer_rdata(xrdata),
    .transfer_rd(xrd), .transfer_wr(xwr), .transfer_addr(xaddr),
    .transfer_wdata(xwdata));

  xfer_bank_model partner (.ref_clk(ref_clk), .ptr(xptr), .wr(xwr),
    .addr(xaddr), .wdata(xwdata), .rdata(xrdata));

  always #5 ref_clk = ~ref_clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobe lowered after its edge, then one idle edge before the next
  task automatic wr(input logic [15:0] ad, input logic [15:0] dt);
    mem_addr = ad;
    mem_wdata = dt;
    mem_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    mem_wr = 1'b0;
    tx_seen = tx_loaded;
    xw_seen = xwr;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rchk(input logic [15:0] ad, input logic [15:0] exp);
    mem_addr = ad;
    mem_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    mem_rd = 1'b0;
    rx_seen = rx_taken;
    xr_seen = xrd;
    chk({15'h0000, mem_rvalid}, 16'h0001);
    chk(mem_rdata, exp);
    @(posedge ref_clk);
    #1;
    chk({15'h0000, mem_rvalid}, 16'h0000);
  endtask

  initial begin
    for (int p = 0; p < 3; p++) begin
      rx_word[p][1] = 16'h9010 + 16'(p);
      rx_word[p][0] = 16'h9020 + 16'(p);
    end
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = {8'h00, dir_a[i]};
      rchk(a, 16'h0000);
      wr(a, 16'hc3a0 ^ a);
      rchk(a, 16'hc3a0 ^ a);
    end
    chk(wcfg, 16'hc388);
    chk(bsw, 16'hc389);
    chk(wctl, 16'hc38b);
    chk(prio, 16'hc3f4);
    chk(clkm, 16'hc3f8);
    // Enable low must swallow both the write and its strobe
    clk_en = 1'b0;
    wr(16'h0029, 16'h5555);
    wr(16'h0023, 16'h5555);
    chk(16'(tx_seen), 16'h0000);
    clk_en = 1'b1;
    chk(bsw, 16'hc389);
    $display("test direct registers done");
    mux_sel = 1'b1;
    rchk(16'h002c, 16'h0000);
    wr(16'h002c, 16'h1234);
    chk(hctl, 16'hc38c);
    mux_sel = 1'b0;
    rchk(16'h002c, 16'hc38c);
    for (int i = 0; i < 9; i++) begin
      wr({8'h00, rsv_a[i]}, 16'hffff);
      rchk({8'h00, rsv_a[i]}, 16'h0000);
    end
    chk(wcfg, 16'hc388);
    $display("test host gating and reserved done");
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 29; i++) begin
        d = 16'h1000 * 16'(p + 1) + 16'(i);
        e = (i == 15 || i == 28) ? 16'h0000 : d;
        wr({8'h00, ptr_a[p]}, 16'(i));
        wr({8'h00, ptr_a[p]} + 16'h0001, d);
        rchk({8'h00, ptr_a[p]}, 16'(i));
        rchk({8'h00, ptr_a[p]} + 16'h0001, e);
        if (i < 28) chk(ser_ctl[p][i], e);
      end
    end
    $display("test serial subbanks done");
    for (int p = 0; p < 3; p++) begin
      a = {8'h00, dat_a[p]};
      rchk(a, 16'h9010 + 16'(p));
      chk(16'(rx_seen), 16'(1 << p));
      rchk(a + 16'h0001, 16'h9020 + 16'(p));
      wr(a + 16'h0002, 16'h4410 + 16'(p));
      chk(16'(tx_seen), 16'(2 << (2 * p)));
      wr(a + 16'h0003, 16'h4420 + 16'(p));
      chk(tx_word[p][1], 16'h4410 + 16'(p));
      chk(tx_word[p][0], 16'h4420 + 16'(p));
    end
    $display("test data words done");
    pin_in = 8'h3c;
    wr(16'h003c, 16'hfff0);
    rchk(16'h003c, 16'h00f0);
    chk({8'h00, pdir}, 16'h00f0);
    wr(16'h003d, 16'h00aa);
    chk({8'h00, plvl}, 16'h00aa);
    rchk(16'h003d, 16'h00ac);
    wr(16'h003e, 16'h0000);
    rchk(16'h003e, 16'h1e07);
    chk({15'h0000, xr_seen}, 16'h0000);
    $display("test pin and identity done");
    wr(16'h0055, 16'h0003);
    wr(16'h0056, 16'hbeef);
    chk({15'h0000, xw_seen}, 16'h0001);
    chk(xptr, 16'h0004);
    rchk(16'h0057, 16'h7004);
    chk({15'h0000, xr_seen}, 16'h0001);
    chk(xptr, 16'h0004);
    rchk(16'h0056, 16'h7004);
    chk(xptr, 16'h0005);
    wr(16'h0055, 16'h0003);
    rchk(16'h0057, 16'hbeef);
    wr(16'h0057, 16'h1357);
    chk({15'h0000, xw_seen}, 16'h0001);
    chk(xaddr, 16'h0003);
    chk(xwdata, 16'h1357);
    chk(xptr, 16'h0003);
    rchk(16'h0057, 16'h1357);
    $display("test transfer subbank done");
    // Mid-run reset clears registers, pointers and banks
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk(wcfg, 16'h0000);
    chk(xptr, 16'h0000);
    chk(ser_ctl[1][27], 16'h0000);
    rchk(16'h0028, 16'h0000);
    $display("test mid-run reset done");
    summarize();
  end
endmodule

// file: tb/xfer_bank_model.sv
// Behavioural transfer subbank answering the window's forwarding strobes
`timescale 1ns/1ps
module xfer_bank_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] ptr,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem [64];
  // Only 64 slots: upper pointer bits fold, enough for short sweeps
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'h7000 + 16'(i);
    end
  end
  // Content follows the pointer with no delay, as the window expects
  assign rdata = mem[ptr[5:0]];
  always @(posedge ref_clk) begin
    if (wr) begin
      mem[addr[5:0]] <= wdata;
    end
  end
endmodule
